/* bsl_blink_timer.sv */
// common blink timebase
`timescale 1ns/1ps
module bsl_blink_timer
   import bsl_pkg::*;
#(
   parameter int unsigned HALF_CYC = BSL_BLINK_CYC
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // phase
   output logic phase_o
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic phase_r;
   logic phase_nxt;

   always_comb begin
      cnt_nxt = cnt_r + 32'h1;
      phase_nxt = phase_r;
      if (cnt_r >= 32'(HALF_CYC - 1)) begin
         cnt_nxt = 32'h0;
         phase_nxt = ~phase_r;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_r <= 32'h0;
         phase_r <= BSL_PHASE_RST;
      end else begin
         cnt_r <= cnt_nxt;
         phase_r <= phase_nxt;
      end
   end

   assign phase_o = phase_r;
endmodule

/* bsl_pkg.sv */
// package for the board status led indicator
package bsl_pkg;
   localparam int unsigned BSL_CLK_HZ = 100_000_000;
   localparam int unsigned BSL_BLINK_MS = 250;
   localparam int unsigned BSL_BLINK_CYC = (BSL_CLK_HZ / 1000) * BSL_BLINK_MS;
   localparam logic [1:0] BSL_PAIR_RST = 2'h3;
   localparam logic [1:0] BSL_CONV_RST = 2'h2;
   localparam logic BSL_PHASE_RST = 1'h0;

   // display pattern of one led pair; index 0 is the first led
   typedef enum logic [3:0] {
      BSL_PAT_OFF = 4'h0,
      BSL_PAT_SECOND = 4'h1,
      BSL_PAT_BOTH = 4'h3,
      BSL_PAT_FIRST = 4'h2,
      BSL_PAT_SIMUL = 4'h6,
      BSL_PAT_FIRST_ON_SECOND_BLINK = 4'h7,
      BSL_PAT_FIRST_BLINK_SECOND_ON = 4'h5,
      BSL_PAT_ALT = 4'h4,
      BSL_PAT_SECOND_BLINK = 4'hc
   } bsl_pat_t;

   // ladder controller power-up progress
   typedef enum logic [1:0] {
      BSL_LC_STOPPED = 2'h0,
      BSL_LC_INIT    = 2'h1,
      BSL_LC_LOAD    = 2'h3,
      BSL_LC_NORMAL  = 2'h2
   } bsl_lc_state_t;

   // conversational processor progress
   typedef enum logic [1:0] {
      BSL_CV_WAIT_ID = 2'h0,
      BSL_CV_INIT    = 2'h1,
      BSL_CV_NORMAL  = 2'h3
   } bsl_cv_state_t;

   // led pair value for a pattern at the given blink phase
   function automatic logic [1:0] bsl_pat_leds(input bsl_pat_t pat, input logic ph);
      logic [1:0] v;
      v = 2'h0;
      unique case (pat)
         BSL_PAT_OFF: v = 2'h0;
         BSL_PAT_SECOND: v = 2'h2;
         BSL_PAT_FIRST: v = 2'h1;
         BSL_PAT_BOTH: v = 2'h3;
         BSL_PAT_SIMUL: v = {ph, ph};
         BSL_PAT_ALT: v = {~ph, ph};
         BSL_PAT_FIRST_ON_SECOND_BLINK: v = {ph, 1'b1};
         BSL_PAT_FIRST_BLINK_SECOND_ON: v = {1'b1, ph};
         BSL_PAT_SECOND_BLINK: v = {ph, 1'b0};
      endcase
      return v;
   endfunction
endpackage

/* bsl_sync.sv */
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module bsl_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // levels
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] q_r;

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d_i;
         q_r <= meta_r;
      end
   end

   assign q_o = q_r;
endmodule

/* bsl_testbench.sv */
// self-checking bench for the board status led indicator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((e) !== (g)) begin n_fail++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
   localparam int HALF = 8;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [16:0] st = '0;
   logic [1:0] lc_led_o;
   logic [1:0] conv_led_o;
   logic [3:0] alarm_led_o;
   int n_fail = 0;
   int checks_done = 0;
   integer seed = 32'hf32d73ae;
   logic [5:0] q[$];
   logic busy = 1'b0;
   // rows: input vector, controller code, conversational code
   logic [24:0] tbl [15] = '{
      25'h0000032, 25'h0100321, 25'h0300510, 25'h0300100, 25'h0300030,
      25'h0300944, 25'h0301160, 25'h0302160, 25'h0304170, 25'h0308180,
      25'h0310150, 25'h0320150, 25'h0700108, 25'h0b00105, 25'h1300101
   };

   always #5 clock_i = ~clock_i;

   bsl_top #(.BLINK_HALF_CYC(HALF)) bsl_top_i (
      .clock_i(clock_i), .arst_n_i(arst_n_i),
      .lc_running_i(st[0]), .lc_init_busy_i(st[1]), .lc_load_busy_i(st[2]),
      .other_board_err_i(st[3]), .discrete_io_err_i(st[4]), .main_mem_bad_i(st[5]),
      .engine_bus_controller_parity_i(st[6]), .cpu_access_parity_i(st[7]),
      .lc_cpu_fault_i(st[8]), .lc_rom_bad_i(st[9]),
      .lc_system_fail_i(st[10]), .serial_io_link_err_i(st[11]),
      .conv_id_set_i(st[12]), .conv_init_done_i(st[13]), .conv_ram_parity_i(st[14]),
      .conv_rom_bad_i(st[15]), .conv_illegal_i(st[16]),
      .lc_led_o(lc_led_o), .conv_led_o(conv_led_o), .alarm_led_o(alarm_led_o)
   );

   // pattern class: 0-3 steady, 4 together, 5 alternate, 6/7/8 one steady one blinking
   function automatic logic [3:0] cls(logic [1:0] s0, logic [1:0] s1, logic eq, logic df, logic [1:0] v);
      logic [1:0] t;
      t = s0 & s1;
      if (t == 2'b00) return {2'b00, v};
      if (t == 2'b11) return eq ? 4'h4 : (df ? 4'h5 : 4'hf);
      if (t == 2'b10) return !s0[0] ? 4'h6 : (!s1[0] ? 4'h8 : 4'hf);
      return !s0[1] ? 4'h7 : 4'hf;
   endfunction

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic apply(input logic [16:0] v);
      @(posedge clock_i);
      st <= v;
      repeat (8) @(posedge clock_i);
   endtask

   task automatic note(input logic [5:0] n);
      q.push_back(n);
      while (q.size() != 0 || busy) begin
         @(negedge clock_i);
      end
   endtask

   // watcher: takes the oldest note and observes a full blink cycle
   initial begin : mon
      logic [5:0] n;
      logic [1:0] p;
      logic [1:0] s0;
      logic [1:0] s1;
      logic eq;
      logic df;
      logic [3:0] a;
      forever begin
         while (q.size() == 0) begin
            @(negedge clock_i);
         end
         busy = 1'b1;
         n = q.pop_front();
         s0 = 2'b00;
         s1 = 2'b00;
         eq = 1'b1;
         df = 1'b1;
         @(negedge clock_i);
         a = alarm_led_o;
         repeat (2 * HALF + 4) begin
            @(negedge clock_i);
            p = n[4] ? conv_led_o : lc_led_o;
            s0 |= ~p;
            s1 |= p;
            eq &= (p[0] === p[1]);
            df &= (p[0] !== p[1]);
         end
         if (n[5:4] == 2'd0) begin
            `CHK("lc_led_o", n[3:0], cls(s0, s1, eq, df, p))
         end else if (n[5:4] == 2'd1) begin
            `CHK("conv_led_o", n[3:0], cls(s0, s1, eq, df, p))
         end else begin
            `CHK("alarm_led_o", n[3:0], a)
            `CHK("alarm_led_o", n[3:0], alarm_led_o)
         end
         busy = 1'b0;
      end
   end

   // stimulus
   initial begin : drv
      logic [31:0] r;
      repeat (3) @(posedge clock_i);
      `CHK("lc_led_o", 2'h3, lc_led_o)
      `CHK("conv_led_o", 2'h2, conv_led_o)
      arst_n_i <= 1'b1;
      foreach (tbl[i]) begin
         apply(tbl[i][24:8]);
         note({2'd0, tbl[i][7:4]});
         note({2'd1, tbl[i][3:0]});
         $display("test row %0d done", i);
      end
      for (int k = 0; k < 8; k++) begin
         r = $random(seed);
         apply({5'h0, r[2], r[1], 2'h0, r[3], 6'h0, r[0]} | 17'h3000);
         note({2'd2, r[3], r[2], ~r[0], r[1]});
         $display("test alarm %0d done", k);
      end
      @(posedge clock_i);
      arst_n_i <= 1'b0;
      st <= '0;
      @(posedge clock_i);
      `CHK("lc_led_o", 2'h3, lc_led_o)
      `CHK("conv_led_o", 2'h2, conv_led_o)
      `CHK("alarm_led_o", 4'h0, alarm_led_o)
      arst_n_i <= 1'b1;
      apply(tbl[1][24:8]);
      note({2'd0, tbl[1][7:4]});
      note({2'd1, tbl[1][3:0]});
      $display("test second reset done");
      tally_and_finish();
   end

   // watchdog
   initial begin
      repeat (20000) @(posedge clock_i);
      n_fail++;
      tally_and_finish();
   end
endmodule

/* bsl_top.sv */
// status and alarm led driver for the controller board
`timescale 1ns/1ps
module bsl_top
   import bsl_pkg::*;
#(
   parameter int unsigned BLINK_HALF_CYC = BSL_BLINK_CYC
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // ladder controller progress
   input wire logic lc_running_i,
   input wire logic lc_init_busy_i,
   input wire logic lc_load_busy_i,
   // ladder controller errors
   input wire logic other_board_err_i,
   input wire logic discrete_io_err_i,
   input wire logic main_mem_bad_i,
   input wire logic engine_bus_controller_parity_i,
   input wire logic cpu_access_parity_i,
   input wire logic lc_cpu_fault_i,
   input wire logic lc_rom_bad_i,
   // alarm causes
   input wire logic lc_system_fail_i,
   input wire logic serial_io_link_err_i,
   // conversational processor
   input wire logic conv_id_set_i,
   input wire logic conv_init_done_i,
   input wire logic conv_ram_parity_i,
   input wire logic conv_rom_bad_i,
   input wire logic conv_illegal_i,
   // leds
   output logic [1:0] lc_led_o,
   output logic [1:0] conv_led_o,
   output logic [3:0] alarm_led_o
);
   localparam int NIN = 17;

   logic [NIN-1:0] raw;
   logic [NIN-1:0] syn;
   logic phase;

   logic s_run, s_init, s_load, s_other, s_dio, s_mem, s_bcp, s_cpp, s_flt, s_rom;
   logic s_sf, s_sio, s_id, s_cdone, s_cpar, s_crom, s_cill;

   bsl_lc_state_t lc_st_r;
   bsl_lc_state_t lc_st_nxt;
   bsl_cv_state_t cv_st_r;
   bsl_cv_state_t cv_st_nxt;
   bsl_pat_t lc_pat;
   bsl_pat_t cv_pat;
   logic [1:0] lc_led_r;
   logic [1:0] lc_led_nxt;
   logic [1:0] conv_led_r;
   logic [1:0] conv_led_nxt;
   logic [3:0] alarm_r;
   logic [3:0] alarm_nxt;

   assign raw = {conv_illegal_i, conv_rom_bad_i, conv_ram_parity_i, conv_init_done_i, conv_id_set_i,
                 serial_io_link_err_i, lc_system_fail_i, lc_rom_bad_i, lc_cpu_fault_i, cpu_access_parity_i,
                 engine_bus_controller_parity_i, main_mem_bad_i, discrete_io_err_i, other_board_err_i,
                 lc_load_busy_i, lc_init_busy_i, lc_running_i};

   bsl_sync #(
      .WIDTH(NIN)
   ) u_sync (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .d_i(raw),
      .q_o(syn)
   );

   assign {s_cill, s_crom, s_cpar, s_cdone, s_id, s_sio, s_sf, s_rom, s_flt, s_cpp, s_bcp, s_mem,
           s_dio, s_other, s_load, s_init, s_run} = syn;

   bsl_blink_timer #(
      .HALF_CYC(BLINK_HALF_CYC)
   ) u_blink (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .phase_o(phase)
   );

   // controller power-up sequence
   always_comb begin
      lc_st_nxt = lc_st_r;
      unique case (lc_st_r)
         BSL_LC_STOPPED: if (s_run) begin
            lc_st_nxt = BSL_LC_INIT;
         end
         BSL_LC_INIT: if (!s_init) begin
            lc_st_nxt = BSL_LC_LOAD;
         end
         BSL_LC_LOAD: if (!s_load) begin
            lc_st_nxt = BSL_LC_NORMAL;
         end
         BSL_LC_NORMAL: lc_st_nxt = BSL_LC_NORMAL;
      endcase
      if (!s_run) begin
         lc_st_nxt = BSL_LC_STOPPED;
      end
   end

   // conversational progress
   always_comb begin
      cv_st_nxt = cv_st_r;
      unique case (cv_st_r)
         BSL_CV_WAIT_ID: if (s_id) begin
            cv_st_nxt = BSL_CV_INIT;
         end
         BSL_CV_INIT: if (s_cdone) begin
            cv_st_nxt = BSL_CV_NORMAL;
         end
         BSL_CV_NORMAL: cv_st_nxt = BSL_CV_NORMAL;
         default: cv_st_nxt = BSL_CV_WAIT_ID;
      endcase
   end

   // controller pair pattern, errors before progress while running; both lit while stopped
   always_comb begin
      lc_pat = BSL_PAT_OFF;
      unique case (lc_st_r)
         BSL_LC_STOPPED: lc_pat = BSL_PAT_BOTH;
         BSL_LC_INIT: lc_pat = BSL_PAT_SECOND;
         BSL_LC_LOAD: lc_pat = BSL_PAT_FIRST;
         BSL_LC_NORMAL: lc_pat = BSL_PAT_OFF;
      endcase
      if (!s_run) begin
         lc_pat = BSL_PAT_BOTH;
      end
      if (s_run) begin
         if (s_cpp) begin
            lc_pat = BSL_PAT_SECOND_BLINK;
         end
         if (s_bcp) begin
            lc_pat = BSL_PAT_FIRST_BLINK_SECOND_ON;
         end
         if (s_dio || s_mem) begin
            lc_pat = BSL_PAT_FIRST_ON_SECOND_BLINK;
         end
         if (s_flt || s_rom) begin
            lc_pat = BSL_PAT_ALT;
         end
         if (s_other) begin
            lc_pat = BSL_PAT_SIMUL;
         end
      end
   end

   // conversational pair pattern, independent of controller state; other board error blinks it, in step with the controller pair only while running
   always_comb begin
      cv_pat = BSL_PAT_SECOND;
      unique case (cv_st_r)
         BSL_CV_WAIT_ID: cv_pat = BSL_PAT_SECOND;
         BSL_CV_INIT: cv_pat = BSL_PAT_FIRST;
         BSL_CV_NORMAL: cv_pat = BSL_PAT_OFF;
         default: cv_pat = BSL_PAT_SECOND;
      endcase
      if (s_cill) begin
         cv_pat = BSL_PAT_FIRST;
      end
      if (s_cpar) begin
         cv_pat = BSL_PAT_SECOND_BLINK;
      end
      if (s_crom) begin
         cv_pat = BSL_PAT_ALT;
      end
      if (s_other) begin
         cv_pat = BSL_PAT_SIMUL;
      end
   end

   // led registers
   always_comb begin
      lc_led_nxt = bsl_pat_leds(lc_pat, phase);
      conv_led_nxt = bsl_pat_leds(cv_pat, phase);
      if (lc_pat == BSL_PAT_ALT) begin
         lc_led_nxt = {~phase, phase};
      end
      alarm_nxt = {s_cpp | s_bcp, s_sio, ~s_run, s_sf};
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lc_st_r <= BSL_LC_STOPPED;
         cv_st_r <= BSL_CV_WAIT_ID;
         lc_led_r <= BSL_PAIR_RST;
         conv_led_r <= BSL_CONV_RST;
         alarm_r <= 4'h0;
      end else begin
         lc_st_r <= lc_st_nxt;
         cv_st_r <= cv_st_nxt;
         lc_led_r <= lc_led_nxt;
         conv_led_r <= conv_led_nxt;
         alarm_r <= alarm_nxt;
      end
   end

   assign lc_led_o = lc_led_r;
   assign conv_led_o = conv_led_r;
   assign alarm_led_o = alarm_r;

   // checks on the pair and alarm drivers
   logic lc_err;
   assign lc_err = s_other | s_dio | s_mem | s_bcp | s_cpp | s_flt | s_rom;

   property p_lc_stopped;
      @(posedge clock_i) disable iff (!arst_n_i)
      !s_run |=> lc_led_r == 2'h3;
   endproperty
   a_lc_stopped: assert property (p_lc_stopped)
      else $error("controller pair not fully lit while stopped");

   property p_lc_init;
      @(posedge clock_i) disable iff (!arst_n_i)
      s_run && !lc_err && lc_st_r == BSL_LC_INIT |=> lc_led_r == 2'h2;
   endproperty
   a_lc_init: assert property (p_lc_init)
      else $error("controller pair wrong during initialization");

   property p_lc_load;
      @(posedge clock_i) disable iff (!arst_n_i)
      s_run && !lc_err && lc_st_r == BSL_LC_LOAD |=> lc_led_r == 2'h1;
   endproperty
   a_lc_load: assert property (p_lc_load)
      else $error("controller pair wrong during program load");

   property p_lc_normal;
      @(posedge clock_i) disable iff (!arst_n_i)
      s_run && !lc_err && lc_st_r == BSL_LC_NORMAL |=> lc_led_r == 2'h0;
   endproperty
   a_lc_normal: assert property (p_lc_normal)
      else $error("controller pair not dark in normal state");

   property p_lc_dio;
      @(posedge clock_i) disable iff (!arst_n_i)
      s_run && !s_other && !s_flt && !s_rom && (s_dio || s_mem) |=> lc_led_r[0];
   endproperty
   a_lc_dio: assert property (p_lc_dio)
      else $error("first controller led not lit on transfer error");

   property p_lc_alt;
      @(posedge clock_i) disable iff (!arst_n_i)
      s_run && !s_other && (s_flt || s_rom) |=> lc_led_r[0] != lc_led_r[1];
   endproperty
   a_lc_alt: assert property (p_lc_alt)
      else $error("controller pair not alternating on processor fault");

   property p_cv_wait;
      @(posedge clock_i) disable iff (!arst_n_i)
      cv_st_r == BSL_CV_WAIT_ID && !s_cill && !s_cpar && !s_crom && !s_other |=> conv_led_r == 2'h2;
   endproperty
   a_cv_wait: assert property (p_cv_wait)
      else $error("conversational pair wrong while waiting for id");

   property p_cv_parity;
      @(posedge clock_i) disable iff (!arst_n_i)
      s_cpar && !s_crom && !s_other |=> !conv_led_r[0];
   endproperty
   a_cv_parity: assert property (p_cv_parity)
      else $error("first conversational led lit on ram parity");

   property p_cv_rom;
      @(posedge clock_i) disable iff (!arst_n_i)
      s_crom && !s_other |=> conv_led_r[0] != conv_led_r[1];
   endproperty
   a_cv_rom: assert property (p_cv_rom)
      else $error("conversational pair not alternating on rom defect");

   property p_alarm_stopped;
      @(posedge clock_i) disable iff (!arst_n_i)
      !s_run |=> alarm_r[1];
   endproperty
   a_alarm_stopped: assert property (p_alarm_stopped)
      else $error("stopped alarm led not lit");

   property p_common_phase;
      @(posedge clock_i) disable iff (!arst_n_i)
      s_run && s_other |=> lc_led_r == conv_led_r;
   endproperty
   a_common_phase: assert property (p_common_phase)
      else $error("pairs blink out of step on shared timebase");

   property p_cov_power_up;
      @(posedge clock_i) disable iff (!arst_n_i)
      lc_st_r == BSL_LC_LOAD ##1 lc_st_r == BSL_LC_NORMAL;
   endproperty
   c_power_up: cover property (p_cov_power_up);

   property p_cov_conv_ready;
      @(posedge clock_i) disable iff (!arst_n_i)
      cv_st_r == BSL_CV_INIT ##1 cv_st_r == BSL_CV_NORMAL;
   endproperty
   c_conv_ready: cover property (p_cov_conv_ready);

   property p_cov_other_board;
      @(posedge clock_i) disable iff (!arst_n_i)
      s_run && s_other;
   endproperty
   c_other_board: cover property (p_cov_other_board);

   property p_cov_conv_rom;
      @(posedge clock_i) disable iff (!arst_n_i)
      s_crom && !s_other;
   endproperty
   c_conv_rom: cover property (p_cov_conv_rom);
endmodule
